// file: shared/lpc_pkg.sv
// Shared constants, enumerations and carrier structs for the multibank command legality block.
package lpc_pkg;

	// Core clock period in picoseconds; every cycle count below derives from it.
	localparam int unsigned CLK_PERIOD_PS = 8000;

	// Bank and data geometry, timer and counter widths.
	localparam int unsigned NUM_BANKS = 8;
	localparam int unsigned BANK_W    = 3;
	localparam int unsigned DQ_W      = 16;
	localparam int unsigned TMR_W     = 4;
	localparam int unsigned DEV_TMR_W = 8;
	localparam int unsigned CNT_W     = 8;

	// Interval lengths in nanoseconds.
	localparam int unsigned T_RCD_NS   = 20;
	localparam int unsigned T_RP_NS    = 20;
	localparam int unsigned T_RRD_NS   = 10;
	localparam int unsigned T_MRR_NS   = 16;
	localparam int unsigned T_MRW_NS   = 40;
	localparam int unsigned T_BURST_NS = 32;
	localparam int unsigned T_RESET_NS = 1000;

	// Least times, rounded up to whole core cycles.
	localparam logic [TMR_W-1:0] RCD_CYC =
		TMR_W'((T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] RP_CYC =
		TMR_W'((T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] RRD_CYC =
		TMR_W'((T_RRD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] BURST_CYC =
		TMR_W'((T_BURST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] AP_CYC = TMR_W'(BURST_CYC + RP_CYC);
	localparam logic [DEV_TMR_W-1:0] MRR_CYC =
		DEV_TMR_W'((T_MRR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [DEV_TMR_W-1:0] MRW_CYC =
		DEV_TMR_W'((T_MRW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [DEV_TMR_W-1:0] RESET_CYC =
		DEV_TMR_W'((T_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// Values after reset.
	localparam logic             CKE_RST   = 1'h0;
	localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;

	// Commands as decoded from the command/address bus.
	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_MRR, CMD_MRW, CMD_REF
	} lpc_cmd_t;

	// Per-bank state.
	typedef enum logic [2:0] {
		BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_READ_AP,
		BK_WRITE_AP, BK_PRECHARGING
	} lpc_bank_state_t;

	// Device-wide state.
	typedef enum logic [2:0] {
		DV_POWER_ON, DV_RESETTING, DV_RUN, DV_MRR_IDLE, DV_MRR_RESET, DV_MRR_ACTIVE, DV_MRW
	} lpc_dev_state_t;

	// Operation handed to one bank tracker.
	typedef enum logic [2:0] {
		BOP_NONE, BOP_ACT, BOP_RD, BOP_WR, BOP_RD_AP, BOP_WR_AP, BOP_PRE, BOP_BST
	} lpc_bank_op_t;

	// One command word as seen on the link.
	typedef struct packed {
		lpc_cmd_t          cmd;
		logic [BANK_W-1:0] bank;
		logic              auto_pre;
		logic              all_banks;
		logic              is_reset;
	} lpc_cmd_word_t;

	// One write data beat with its mask.
	typedef struct packed {
		logic            valid;
		logic            mask;
		logic [DQ_W-1:0] data;
	} lpc_beat_t;

endpackage

// file: rtl/lpc_bank.sv
// State tracker for one bank: row activation, bursts and precharge timing.
`timescale 1ns/1ps
module lpc_bank (
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	input  wire lpc_pkg::lpc_bank_op_t  op_in,
	output lpc_pkg::lpc_bank_state_t    state_out
);
	import lpc_pkg::*;

	typedef struct packed {
		lpc_bank_state_t  state;
		logic [TMR_W-1:0] timer;
	} lpc_bank_reg_t;

	lpc_bank_reg_t r;
	lpc_bank_reg_t next_r;

	// Timed states leave when their timer reaches one, so a load of N lasts N cycles.
	always_comb begin
		next_r = r;
		if (r.timer != '0) begin
			next_r.timer = r.timer - TMR_W'(1);
		end
		if (r.timer == TMR_W'(1)) begin
			case (r.state)
				BK_ACTIVATING:  next_r.state = BK_ACTIVE;
				BK_READING:     next_r.state = BK_ACTIVE;
				BK_WRITING:     next_r.state = BK_ACTIVE;
				BK_READ_AP:     next_r.state = BK_IDLE;
				BK_WRITE_AP:    next_r.state = BK_IDLE;
				BK_PRECHARGING: next_r.state = BK_IDLE;
				default:        next_r.state = r.state;
			endcase
		end
		// A legal command always overrides the running interval.
		case (op_in)
			BOP_ACT: begin
				next_r.state = BK_ACTIVATING;
				next_r.timer = RCD_CYC;
			end
			BOP_RD: begin
				next_r.state = BK_READING;
				next_r.timer = BURST_CYC;
			end
			BOP_WR: begin
				next_r.state = BK_WRITING;
				next_r.timer = BURST_CYC;
			end
			BOP_RD_AP: begin
				next_r.state = BK_READ_AP;
				next_r.timer = AP_CYC;
			end
			BOP_WR_AP: begin
				next_r.state = BK_WRITE_AP;
				next_r.timer = AP_CYC;
			end
			BOP_PRE: begin
				next_r.state = BK_PRECHARGING;
				next_r.timer = RP_CYC;
			end
			BOP_BST: begin
				next_r.state = BK_ACTIVE;
				next_r.timer = '0;
			end
			default: begin
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			r <= '{state: BK_IDLE, timer: '0};
		end else begin
			r <= next_r;
		end
	end

	assign state_out = r.state;

endmodule // lpc_bank

// file: rtl/lpc_multibank_legality.sv
// Multibank command legality checker: link capture, clock crossing and bank bookkeeping.
//
// Contract
// - Commands count only when clock enable was high on previous and current edge.
// - A bank is idle after precharge once the precharge period has elapsed.
// - A bank is active once row open, activation time met, nothing in progress.
// - Bursts without auto precharge hold reading or writing until complete or terminated; code also lets a precharge to that bank end them.
// - Burst terminate only acts on the bank whose burst is running.
// - Burst terminate needs an ongoing burst and returns that bank to active.
// - After a mode-register write, or idle/reset register read, all banks are idle.
// - After a register read issued with an active bank, that bank stays active.
// - Reads and writes to other banks may use auto precharge or not.
// - Register read is allowed while banks activate or precharge; they follow own state.
// - Auto-precharge banks take no commands; other banks take any valid command.
// - Reset is a register write from power-on, needs all idle, enters resetting.
// - A register read while resetting opens a resetting register-read interval.
// - Activate to an idle bank opens its row whatever other banks are doing; code refuses it while rrd_timer runs.
// - Write beats with mask low are stored, beats with mask high are dropped.
// - Precharging lasts from the precharge command until the precharge period elapses.
// - Row activating lasts from activate until the activation time elapses.
`timescale 1ns/1ps
module lpc_multibank_legality (
	input  wire logic                     clk_in,
	input  wire logic                     sys_rst_in,
	input  wire logic                     link_clk_in,
	input  wire logic                     cke_in,
	input  wire lpc_pkg::lpc_cmd_word_t   cmd_in,
	input  wire lpc_pkg::lpc_beat_t       beat_in,
	output lpc_pkg::lpc_bank_state_t      bank_state_out [lpc_pkg::NUM_BANKS],
	output lpc_pkg::lpc_dev_state_t       dev_state_out,
	output logic                          cmd_taken_out,
	output logic                          cmd_refused_out,
	output logic                          overrun_out,
	output logic                          store_valid_out,
	output logic [lpc_pkg::DQ_W-1:0]      store_data_out,
	output logic [lpc_pkg::CNT_W-1:0]     store_count_out
);
	import lpc_pkg::*;

	// Link-domain state: everything clocked by the controller's clock.
	typedef struct packed {
		logic             rst_s1;
		logic             rst_s2;
		logic             cke_prev;
		logic             req;
		lpc_cmd_word_t    word;
		logic             ack_s1;
		logic             ack_s2;
		logic             wr_s1;
		logic             wr_s2;
		logic             ovr;
		logic             store_valid;
		logic [DQ_W-1:0]  store_data;
		logic [CNT_W-1:0] store_count;
	} lpc_link_reg_t;

	// Core-domain state.
	typedef struct packed {
		logic                 req_s1;
		logic                 req_s2;
		logic                 req_s3;
		logic                 ack;
		logic                 ovr_s1;
		logic                 ovr_s2;
		lpc_dev_state_t       dev;
		logic [DEV_TMR_W-1:0] dev_timer;
		logic [TMR_W-1:0]     rrd_timer;
		logic [BANK_W-1:0]    burst_bank;
		logic                 taken;
		logic                 refused;
		logic                 writing;
	} lpc_core_reg_t;

	lpc_link_reg_t   l;
	lpc_link_reg_t   next_l;
	lpc_core_reg_t   c;
	lpc_core_reg_t   next_c;
	lpc_bank_state_t bank_st [NUM_BANKS];
	lpc_bank_op_t    bank_op [NUM_BANKS];

	// Summary views over all banks for the legality decision and the write-data gate, plus the decision signals.
	logic            all_idle;
	logic            any_reading;
	logic            any_writing;
	logic            any_burst;
	logic            all_pre_ready;
	logic            any_wr_data;
	logic            new_cmd;
	logic            legal;
	lpc_bank_state_t tgt;
	lpc_cmd_word_t   w;

	// ------------------------------------------------------------------
	// Link domain.
	// ------------------------------------------------------------------

	// The link holds one command word until the core acknowledges it, so the
	// core may sample the word directly once the request toggle has settled.
	// Trade-off: there is no queue, so a non-NOP command arriving before the
	// previous handshake closes is dropped and flagged as an overrun.
	always_comb begin
		next_l = l;
		next_l.rst_s1 = sys_rst_in;
		next_l.rst_s2 = l.rst_s1;
		next_l.ack_s1 = c.ack;
		next_l.ack_s2 = l.ack_s1;
		next_l.wr_s1 = c.writing;
		next_l.wr_s2 = l.wr_s1;
		next_l.cke_prev = cke_in;
		next_l.store_valid = 1'h0;
		// Commands only register with clock enable high on both edges.
		if (l.cke_prev && cke_in && (cmd_in.cmd != CMD_NOP)) begin
			if (l.req != l.ack_s2) begin
				next_l.ovr = 1'h1;
			end else begin
				next_l.word = cmd_in;
				next_l.req = ~l.req;
			end
		end
		// Mask sampled with its beat; high mask inhibits the store.
		if (beat_in.valid && l.wr_s2 && !beat_in.mask) begin
			next_l.store_valid = 1'h1;
			next_l.store_data = beat_in.data;
			next_l.store_count = l.store_count + CNT_W'(1);
		end
		// Reset reaches this domain through its own synchroniser.
		if (l.rst_s2) begin
			next_l.cke_prev = CKE_RST;
			next_l.req = 1'h0;
			next_l.word = '0;
			next_l.ovr = 1'h0;
			next_l.store_valid = 1'h0;
			next_l.store_data = '0;
			next_l.store_count = COUNT_RST;
		end
	end

	// Link-domain register; its reset is applied by the process above.
	always_ff @(posedge link_clk_in) begin
		l <= next_l;
	end

	// Stored beats leave straight from link-domain flip-flops.
	assign store_valid_out = l.store_valid;
	assign store_data_out = l.store_data;
	assign store_count_out = l.store_count;

	// ------------------------------------------------------------------
	// Per-bank trackers.
	// ------------------------------------------------------------------

	// One tracker per bank; each keeps its own timers.
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		lpc_bank u_bank (
			.clk_in     (clk_in),
			.sys_rst_in (sys_rst_in),
			.op_in      (bank_op[b]),
			.state_out  (bank_st[b])
		);
		assign bank_state_out[b] = bank_st[b];
	end

	// Summaries across the banks.
	always_comb begin
		all_idle = 1'h1;
		any_reading = 1'h0;
		any_writing = 1'h0;
		any_burst = 1'h0;
		all_pre_ready = 1'h1;
		any_wr_data = 1'h0;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (bank_st[i] != BK_IDLE) begin
				all_idle = 1'h0;
			end
			if (bank_st[i] == BK_READING) begin
				any_reading = 1'h1;
			end
			if (bank_st[i] == BK_WRITING) begin
				any_writing = 1'h1;
			end
			if ((bank_st[i] == BK_READING) || (bank_st[i] == BK_WRITING) ||
				(bank_st[i] == BK_READ_AP) || (bank_st[i] == BK_WRITE_AP)) begin
				any_burst = 1'h1;
			end
			// Activating and auto-precharge banks may not be precharged.
			if ((bank_st[i] == BK_ACTIVATING) || (bank_st[i] == BK_READ_AP) ||
				(bank_st[i] == BK_WRITE_AP)) begin
				all_pre_ready = 1'h0;
			end
			if ((bank_st[i] == BK_WRITING) || (bank_st[i] == BK_WRITE_AP)) begin
				any_wr_data = 1'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Core domain: legality decision.
	// ------------------------------------------------------------------

	// A fresh command shows as a change on the synchronised request toggle.
	assign new_cmd = c.req_s2 != c.req_s3;
	assign w = l.word;
	assign tgt = bank_st[w.bank];

	// Decide whether the pending word is allowed in the present state.
	always_comb begin
		legal = 1'h0;
		case (w.cmd)
			CMD_ACT: begin
				// Target must be idle and the activate gap spent; other banks may be in any state.
				legal = (c.dev == DV_RUN) && (tgt == BK_IDLE)
					&& (c.rrd_timer == '0);
			end
			CMD_RD: begin
				// A write burst without auto precharge still running anywhere blocks the read.
				legal = (c.dev == DV_RUN) && !any_writing
					&& ((tgt == BK_ACTIVE) || (tgt == BK_READING));
			end
			CMD_WR: begin
				// A read burst without auto precharge still running anywhere blocks the write.
				legal = (c.dev == DV_RUN) && !any_reading
					&& ((tgt == BK_ACTIVE) || (tgt == BK_WRITING));
			end
			CMD_PRE: begin
				if (w.all_banks) begin
					legal = (c.dev == DV_RUN) && all_pre_ready;
				end else begin
					// Auto-precharge banks refuse; idle ones still precharge.
					legal = (c.dev == DV_RUN) && (tgt != BK_ACTIVATING) &&
						(tgt != BK_READ_AP) && (tgt != BK_WRITE_AP);
				end
			end
			CMD_BST: begin
				legal = (c.dev == DV_RUN) && (w.bank == c.burst_bank)
					&& ((tgt == BK_READING) || (tgt == BK_WRITING));
			end
			CMD_MRR: begin
				// Activating and precharging banks keep running through the read.
				legal = ((c.dev == DV_RUN) && !any_burst)
					|| (c.dev == DV_RESETTING);
			end
			CMD_MRW: begin
				if (w.is_reset) begin
					legal = (c.dev == DV_POWER_ON) && all_idle && !any_burst;
				end else begin
					legal = (c.dev == DV_RUN) && all_idle;
				end
			end
			CMD_REF: begin
				legal = (c.dev == DV_RUN) && all_idle;
			end
			default: begin
				legal = 1'h0;
			end
		endcase
		// Register read and write intervals take nothing but no-operations.
		if ((c.dev == DV_MRR_IDLE) || (c.dev == DV_MRR_RESET) ||
			(c.dev == DV_MRR_ACTIVE) || (c.dev == DV_MRW)) begin
			legal = 1'h0;
		end
	end

	// Hand the accepted command to the bank trackers.
	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++) begin
			bank_op[i] = BOP_NONE;
			if (new_cmd && legal) begin
				if ((w.cmd == CMD_PRE) && w.all_banks) begin
					bank_op[i] = BOP_PRE;
				end else if (BANK_W'(i) == w.bank) begin
					case (w.cmd)
						CMD_ACT: bank_op[i] = BOP_ACT;
						CMD_RD:  bank_op[i] = w.auto_pre ? BOP_RD_AP : BOP_RD;
						CMD_WR:  bank_op[i] = w.auto_pre ? BOP_WR_AP : BOP_WR;
						CMD_PRE: bank_op[i] = BOP_PRE;
						CMD_BST: bank_op[i] = BOP_BST;
						default: bank_op[i] = BOP_NONE;
					endcase
				end
			end
		end
	end

	// Core next state: synchronisers, device mode and the activate gap.
	always_comb begin
		next_c = c;
		next_c.req_s1 = l.req;
		next_c.req_s2 = c.req_s1;
		next_c.req_s3 = c.req_s2;
		next_c.ack = c.req_s2;
		next_c.ovr_s1 = l.ovr;
		next_c.ovr_s2 = c.ovr_s1;
		next_c.taken = new_cmd && legal;
		next_c.refused = new_cmd && !legal;
		next_c.writing = any_wr_data;
		if (c.rrd_timer != '0) begin
			next_c.rrd_timer = c.rrd_timer - TMR_W'(1);
		end
		if (c.dev_timer != '0) begin
			next_c.dev_timer = c.dev_timer - DEV_TMR_W'(1);
		end
		// Interval end: the device returns to normal operation.
		if (c.dev_timer == DEV_TMR_W'(1)) begin
			case (c.dev)
				DV_MRR_IDLE:   next_c.dev = DV_RUN;
				DV_MRR_RESET:  next_c.dev = DV_RUN;
				DV_MRR_ACTIVE: next_c.dev = DV_RUN;
				DV_MRW:        next_c.dev = DV_RUN;
				DV_RESETTING:  next_c.dev = DV_RUN;
				default:       next_c.dev = c.dev;
			endcase
		end
		if (new_cmd && legal) begin
			case (w.cmd)
				CMD_ACT: begin
					next_c.rrd_timer = RRD_CYC;
				end
				CMD_RD, CMD_WR: begin
					// A later terminate must name this bank.
					next_c.burst_bank = w.bank;
				end
				CMD_MRR: begin
					// Active banks are untouched, so they stay active afterwards.
					if (c.dev == DV_RESETTING) begin
						next_c.dev = DV_MRR_RESET;
					end else if (all_idle) begin
						next_c.dev = DV_MRR_IDLE;
					end else begin
						next_c.dev = DV_MRR_ACTIVE;
					end
					next_c.dev_timer = MRR_CYC;
				end
				CMD_MRW: begin
					if (w.is_reset) begin
						next_c.dev = DV_RESETTING;
						next_c.dev_timer = RESET_CYC;
					end else begin
						next_c.dev = DV_MRW;
						next_c.dev_timer = MRW_CYC;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Core register with synchronous reset.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			c <= '{dev: DV_POWER_ON, default: '0};
		end else begin
			c <= next_c;
		end
	end

	assign dev_state_out = c.dev;
	assign cmd_taken_out = c.taken;
	assign cmd_refused_out = c.refused;
	assign overrun_out = c.ovr_s2;

endmodule // lpc_multibank_legality

// file: test/lpc_checker.sv
// Concurrent checks on the ports of the multibank command legality block.
`timescale 1ns/1ps
module lpc_checker (
	input  wire logic                     clk_in,
	input  wire logic                     sys_rst_in,
	input  wire logic                     link_clk_in,
	input  lpc_pkg::lpc_bank_state_t      bank_state_out [lpc_pkg::NUM_BANKS],
	input  lpc_pkg::lpc_dev_state_t       dev_state_out,
	input  wire logic                     cmd_taken_out,
	input  wire logic                     cmd_refused_out,
	input  wire logic                     store_valid_out,
	input  wire logic [lpc_pkg::CNT_W-1:0] store_count_out
);
	import lpc_pkg::*;
	lpc_bank_state_t b2;
	logic            all_idle;
	logic            in_mr;

	// Bank 2 carries the timing checks; the bench drives it through activate, write bursts and precharge, never a read.
	always_comb begin
		b2 = bank_state_out[2];
		all_idle = 1'h1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (bank_state_out[i] != BK_IDLE) begin
				all_idle = 1'h0;
			end
		end
		in_mr = dev_state_out inside {DV_MRR_IDLE, DV_MRR_RESET, DV_MRR_ACTIVE, DV_MRW};
	end

	sequence s_act_in;
		b2 == BK_ACTIVATING && $past(b2) != BK_ACTIVATING;
	endsequence
	sequence s_pre_in;
		b2 == BK_PRECHARGING && $past(b2) != BK_PRECHARGING;
	endsequence
	sequence s_wr_in;
		b2 == BK_WRITING && $past(b2) != BK_WRITING;
	endsequence

	pulse_excl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!(cmd_taken_out && cmd_refused_out)) else $error("taken and refused together");
	act_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		s_act_in |-> cmd_taken_out ##0 (b2 == BK_ACTIVATING)[*3] ##1 b2 == BK_ACTIVE)
		else $error("activation time wrong");
	pre_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		s_pre_in |-> (b2 == BK_PRECHARGING)[*3] ##1 b2 == BK_IDLE)
		else $error("precharge time wrong");
	wr_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		s_wr_in |-> (b2 == BK_WRITING)[*4] ##1 b2 == BK_ACTIVE)
		else $error("write burst length wrong");
	mrw_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		($past(dev_state_out) == DV_MRW && dev_state_out != DV_MRW) |-> all_idle)
		else $error("banks not idle after mode write");
	mrr_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(dev_state_out == DV_MRR_ACTIVE && b2 == BK_ACTIVE) |=> b2 == BK_ACTIVE)
		else $error("active bank lost during mode read");
	quiet_mr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(in_mr && $past(in_mr)) |-> !cmd_taken_out) else $error("command taken in interval");
	rst_entry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(dev_state_out == DV_RESETTING && $past(dev_state_out) == DV_POWER_ON)
		|-> cmd_taken_out) else $error("resetting entered without command");
	mrr_rst_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(dev_state_out == DV_MRR_RESET && $past(dev_state_out) == DV_RESETTING)
		|-> ##1 dev_state_out == DV_MRR_RESET ##1 dev_state_out == DV_RUN && all_idle)
		else $error("resetting mode read interval wrong");
	store_cnt_a: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		store_valid_out |-> store_count_out == $past(store_count_out) + 8'h01)
		else $error("stored beat not counted");
endmodule // lpc_checker

bind lpc_multibank_legality lpc_checker i_lpc_checker (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk_in),
	.bank_state_out(bank_state_out), .dev_state_out(dev_state_out),
	.cmd_taken_out(cmd_taken_out), .cmd_refused_out(cmd_refused_out),
	.store_valid_out(store_valid_out), .store_count_out(store_count_out)
);

// file: test/lpc_ctrl_model.sv
// Controller-side model that drives command words and write beats on the link clock.
`timescale 1ns/1ps
module lpc_ctrl_model (
	input  wire logic             link_clk_in,
	output logic                  cke_out,
	output lpc_pkg::lpc_cmd_word_t cmd_out,
	output lpc_pkg::lpc_beat_t    beat_out
);
	import lpc_pkg::*;

	// Clock enable starts high; send drops it for one word only when ck is low, so that word fails the two-edge condition.
	initial begin
		cke_out = 1'h1;
		cmd_out = '0;
		beat_out = '0;
	end

	// One word for one link cycle, then back to no-operation.
	task automatic send(input lpc_cmd_word_t w, input logic ck);
		@(posedge link_clk_in);
		#1;
		cmd_out = w;
		cke_out = ck;
		@(posedge link_clk_in);
		#1;
		cmd_out = '0;
		cke_out = 1'h1;
	endtask

	// Released data is inverted so a stale beat never looks like fresh data.
	task automatic beats(input int n, input logic m, input logic [DQ_W-1:0] d);
		repeat (n) begin
			@(posedge link_clk_in);
			#1;
			beat_out = '{1'h1, m, d};
		end
		@(posedge link_clk_in);
		#1;
		beat_out = '{1'h0, 1'h0, ~d};
	endtask
endmodule // lpc_ctrl_model

// file: test/testbench.sv
// Self-checking bench for the multibank command legality block.
`timescale 1ns/1ps
module testbench;
	import lpc_pkg::*;
	logic            clk_in = 1'h0;
	logic            link_clk_in = 1'h0;
	logic            sys_rst_in = 1'h1;
	logic            cke_in;
	lpc_cmd_word_t   cmd_in;
	lpc_beat_t       beat_in;
	lpc_bank_state_t bank_state_out [NUM_BANKS];
	lpc_dev_state_t  dev_state_out;
	logic            cmd_taken_out;
	logic            cmd_refused_out;
	logic            overrun_out;
	logic            store_valid_out;
	logic [DQ_W-1:0] store_data_out;
	logic [CNT_W-1:0] store_count_out;
	int              n_fail = 0;
	int              checked = 0;

	// Core clock at 8 ns; link clock at 15 ns with an odd phase offset.
	always #4 clk_in = ~clk_in;
	initial begin
		#2.3;
		forever #7.5 link_clk_in = ~link_clk_in;
	end

	lpc_multibank_legality i_lpc_multibank_legality (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk_in),
		.cke_in(cke_in), .cmd_in(cmd_in), .beat_in(beat_in),
		.bank_state_out(bank_state_out), .dev_state_out(dev_state_out),
		.cmd_taken_out(cmd_taken_out), .cmd_refused_out(cmd_refused_out),
		.overrun_out(overrun_out), .store_valid_out(store_valid_out),
		.store_data_out(store_data_out), .store_count_out(store_count_out));
	lpc_ctrl_model i_lpc_ctrl_model (.link_clk_in(link_clk_in), .cke_out(cke_in),
		.cmd_out(cmd_in), .beat_out(beat_in));

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Expected answer: 1 taken, 2 refused, 0 silence; the leading gap keeps handshakes apart.
	task automatic issue(input lpc_cmd_t c, input logic [2:0] b, input logic [2:0] f,
		input logic ck, input logic [1:0] exp);
		logic [1:0] r;
		r = 2'h0;
		repeat (4) @(posedge link_clk_in);
		i_lpc_ctrl_model.send('{c, b, f[2], f[1], f[0]}, ck);
		for (int i = 0; i < 20 && r == 2'h0; i++) begin
			@(posedge clk_in);
			#1;
			if (cmd_taken_out === 1'h1) begin
				r = 2'h1;
			end else if (cmd_refused_out === 1'h1) begin
				r = 2'h2;
			end
		end
		check("answer", 16'(r), 16'(exp));
	endtask

	task automatic s_power_on();
		check("dev", 16'(dev_state_out), 16'(DV_POWER_ON));
		check("bank", 16'(bank_state_out[2]), 16'(BK_IDLE));
		issue(CMD_ACT, 3'h2, 3'h0, 1'h1, 2'h2);
		issue(CMD_MRW, 3'h0, 3'h1, 1'h1, 2'h1);
		check("dev", 16'(dev_state_out), 16'(DV_RESETTING));
		issue(CMD_MRR, 3'h0, 3'h0, 1'h1, 2'h1);
		check("dev", 16'(dev_state_out), 16'(DV_MRR_RESET));
		repeat (3) @(posedge clk_in);
		#1;
		check("dev", 16'(dev_state_out), 16'(DV_RUN));
	endtask

	task automatic s_act_pre();
		issue(CMD_ACT, 3'h2, 3'h0, 1'h0, 2'h0);
		issue(CMD_ACT, 3'h2, 3'h0, 1'h1, 2'h1);
		check("bank", 16'(bank_state_out[2]), 16'(BK_ACTIVATING));
		repeat (3) @(posedge clk_in);
		#1;
		check("bank", 16'(bank_state_out[2]), 16'(BK_ACTIVE));
		issue(CMD_ACT, 3'h5, 3'h0, 1'h1, 2'h1);
		issue(CMD_ACT, 3'h5, 3'h0, 1'h1, 2'h2);
		issue(CMD_RD, 3'h3, 3'h0, 1'h1, 2'h2);
		issue(CMD_PRE, 3'h5, 3'h0, 1'h1, 2'h1);
		check("bank", 16'(bank_state_out[5]), 16'(BK_PRECHARGING));
		repeat (3) @(posedge clk_in);
		#1;
		check("bank", 16'(bank_state_out[5]), 16'(BK_IDLE));
	endtask

	task automatic s_write();
		logic [CNT_W-1:0] v;
		v = store_count_out;
		fork
			i_lpc_ctrl_model.beats(20, 1'h1, 16'h3C5A);
			issue(CMD_WR, 3'h2, 3'h0, 1'h1, 2'h1);
		join
		check("count", 16'(store_count_out), 16'(v));
		check("bank", 16'(bank_state_out[2]), 16'(BK_ACTIVE));
		issue(CMD_BST, 3'h2, 3'h0, 1'h1, 2'h2);
		fork
			i_lpc_ctrl_model.beats(20, 1'h0, 16'hA5C3);
			issue(CMD_WR, 3'h2, 3'h0, 1'h1, 2'h1);
		join
		check("stored", 16'(store_count_out != v), 16'h0001);
		check("data", store_data_out, 16'hA5C3);
		v = store_count_out;
		i_lpc_ctrl_model.beats(6, 1'h0, 16'h1234);
		repeat (2) @(posedge link_clk_in);
		#1;
		check("count", 16'(store_count_out), 16'(v));
	endtask

	task automatic s_modes();
		issue(CMD_MRR, 3'h2, 3'h0, 1'h1, 2'h1);
		check("dev", 16'(dev_state_out), 16'(DV_MRR_ACTIVE));
		repeat (3) @(posedge clk_in);
		#1;
		check("bank", 16'(bank_state_out[2]), 16'(BK_ACTIVE));
		issue(CMD_MRW, 3'h0, 3'h0, 1'h1, 2'h2);
		issue(CMD_REF, 3'h0, 3'h0, 1'h1, 2'h2);
		issue(CMD_ACT, 3'h6, 3'h0, 1'h1, 2'h1);
		issue(CMD_RD, 3'h6, 3'h4, 1'h1, 2'h1);
		check("bank", 16'(bank_state_out[6]), 16'(BK_READ_AP));
		repeat (8) @(posedge clk_in);
		#1;
		check("bank", 16'(bank_state_out[6]), 16'(BK_IDLE));
		issue(CMD_PRE, 3'h0, 3'h2, 1'h1, 2'h1);
		repeat (4) @(posedge clk_in);
		#1;
		check("bank", 16'(bank_state_out[2]), 16'(BK_IDLE));
		issue(CMD_MRW, 3'h0, 3'h0, 1'h1, 2'h1);
		check("dev", 16'(dev_state_out), 16'(DV_MRW));
		repeat (5) @(posedge clk_in);
		#1;
		check("dev", 16'(dev_state_out), 16'(DV_RUN));
		issue(CMD_REF, 3'h0, 3'h0, 1'h1, 2'h1);
		check("overrun", 16'(overrun_out), 16'h0000);
	endtask

	task automatic summarize();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reset is held for eight core cycles, then the link is given time to leave reset.
	initial begin
		repeat (8) @(posedge clk_in);
		#1;
		sys_rst_in = 1'h0;
		repeat (10) @(posedge link_clk_in);
		s_power_on();
		s_act_pre();
		s_write();
		s_modes();
		summarize();
	end

	// The tests need about 4 us; a hang beyond 60 us ends the run as a failure.
	initial begin
		#60000;
		n_fail++;
		summarize();
	end
endmodule // testbench
